//--- core/can_master_control_cfg.svh
// Offsets, field positions, reset values and bit-time counts of the
// CAN master control block.
// Assumes 32-bit APB data with one register to each aligned word.
`ifndef CAN_MASTER_CONTROL_CFG_SVH
`define CAN_MASTER_CONTROL_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004

// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define CTRL_RESET 32'h0001_0002
`define CTRL_WMASK 32'h0001_00FF
`define READ_ZERO 32'h0000_0000

// ****************************************************************
// Control register field positions
// ****************************************************************
`define DBG_TX_BLOCK_BIT 16
`define PARTIAL_RESET_BIT 15
`define TIME_TRIG_BIT 7
`define AUTO_BUSOFF_BIT 6
`define AUTO_SLEEP_BIT 5
`define RETX_PROHIBIT_BIT 4
`define DISCARD_SEL_BIT 3
`define PRIO_RULE_BIT 2
`define SLEEP_REQ_BIT 1
`define FREEZE_REQ_BIT 0

// ****************************************************************
// Status register field positions
// ****************************************************************
`define FREEZE_ACK_BIT 0
`define SLEEP_ACK_BIT 1

// ****************************************************************
// Bus timing counts, in sampled bit times, recessive runs and FIFO messages
// ****************************************************************
`define RECESSIVE_RUN_LEN 11
`define BUSOFF_RUN_COUNT 128
`define FIFO_FULL_COUNT 2'h3

`endif

//--- core/can_master_control_pkg.sv
// Types shared by the CAN master control block.
// Assumes nothing of its surroundings.
package can_master_control_pkg;

   // Operating modes of the controller
   typedef enum logic [1:0]
   {
      MODE_SLEEP = 2'b00,
      MODE_FREEZE = 2'b01,
      MODE_SYNC = 2'b10,
      MODE_ONLINE = 2'b11
   } mode_t;

endpackage

//--- core/recessive_run_detect.sv
// Detector of runs of consecutive recessive bits on the receive line.
// Assumes one sampleTick pulse per bit sample point.
`timescale 1ns/1ps

module recessive_run_detect
#(
   parameter int RUN_LEN = 11
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bit stream
   input wire logic clear,
   input wire logic sampleTick,
   input wire logic rxLevel,
   // Result
   output logic runDone
);

   localparam int CW = $clog2(RUN_LEN + 1);
   localparam logic [CW-1:0] LAST = CW'(RUN_LEN - 1);

   logic [CW-1:0] runCount;
   logic [CW-1:0] next_runCount;
   logic next_runDone;

   // Count recessive samples, restart on a dominant one
   always_comb
   begin
      next_runCount = runCount;
      next_runDone = 1'b0;
      if (clear)
         next_runCount = '0;
      else if (sampleTick)
      begin
         if (!rxLevel)
            next_runCount = '0;
         else if (runCount == LAST)
         begin
            next_runCount = '0;
            next_runDone = 1'b1;
         end
         else
            next_runCount = runCount + 1'b1;
      end
   end

   // Counter and pulse registers
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         runCount <= '0;
         runDone <= 1'b0;
      end
      else
      begin
         runCount <= next_runCount;
         runDone <= next_runDone;
      end
   end

endmodule

//--- core/event_counter.sv
// Counter of event pulses that flags when a set number is reached.
// Assumes eventIn is a one-cycle pulse.
`timescale 1ns/1ps

module event_counter
#(
   parameter int COUNT = 128
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Events
   input wire logic clear,
   input wire logic eventIn,
   // Result
   output logic reached
);

   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   logic [CW-1:0] eventCount;
   logic [CW-1:0] next_eventCount;
   logic next_reached;

   // Count events and restart after the last one
   always_comb
   begin
      next_eventCount = eventCount;
      next_reached = 1'b0;
      if (clear)
         next_eventCount = '0;
      else if (eventIn)
      begin
         if (eventCount == LAST)
         begin
            next_eventCount = '0;
            next_reached = 1'b1;
         end
         else
            next_eventCount = eventCount + 1'b1;
      end
   end

   // Counter and pulse registers
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         eventCount <= '0;
         reached <= 1'b0;
      end
      else
      begin
         eventCount <= next_eventCount;
         reached <= next_reached;
      end
   end

endmodule

//--- core/can_master_control.sv
// Master control register and mode logic of a CAN controller,
// reached as an APB slave.
// Assumes a bit-sample tick, a receive level and activity flags from
// the protocol engine, and halt and pause levels from the debug unit.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "can_master_control_cfg.svh"

// Contract
// - Debug transmit block resets set, receive unaffected
// - Block only with both bits and halt
// - Partial reset clears receive FIFOs, control only
// - Partial reset enters sleep, self-clears
// - Time-triggered bit drives time-triggered mode
// - Auto bus-off exit on exit timing
// - Else freeze cycle needed before exit
// - Manual sleep exit by clearing request
// - Auto sleep exit on bus message
// - Prohibit bit stops retransmission of failures
// - Overflow discards oldest or newest message
// - Priority by identifier or request order
// - Sleep request resets set, requests sleep
// - Any reset forces sleep request set
// - Freeze entered only after bus activity
// - Freeze exit waits eleven recessive bits
// - Reserved bits read zero, ignore writes
// - Exit timing is 128 recessive runs
// - Overflow means valid message at three
// - Sleep acknowledge shows actual sleep
module can_master_control
#(
   parameter int ADDR_WIDTH = 12,
   parameter int RUN_LEN = `RECESSIVE_RUN_LEN,
   parameter int BUSOFF_RUNS = `BUSOFF_RUN_COUNT
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Protocol engine inputs
   input wire logic sampleTick,
   input wire logic rxLevel,
   input wire logic busActive,
   input wire logic sofDetected,
   input wire logic busOffEnter,
   // Debug unit inputs
   input wire logic debugHalt,
   input wire logic debugCanPause,
   // Receive FIFO interface
   input wire logic rxValidMessage,
   input wire logic [1:0] rxFifoMessageCount,
   output logic rxFifoReset,
   output logic discardOldest,
   output logic dropIncoming,
   // Mode and option outputs
   output logic timeTriggeredMode,
   output logic retransmitProhibit,
   output logic txPriorityRule,
   output logic txBlocked,
   output logic txAllowed,
   output logic busOnline,
   output logic busOff,
   output logic sleepAck,
   output logic freezeAck
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic partialPending;
   logic next_partialPending;
   logic [31:0] next_prdata;
   logic [31:0] readValue;
   logic [ADDR_WIDTH-1:0] ctrlAddr;
   logic [ADDR_WIDTH-1:0] statusAddr;
   logic hitCtrl;
   logic hitStatus;
   logic mapped;
   logic setupCycle;
   logic accessCycle;
   logic wrCtrl;
   can_master_control_pkg::mode_t mode;
   can_master_control_pkg::mode_t next_mode;
   logic sleepReq;
   logic freezeReq;
   logic autoSleepExit;
   logic autoBusoffExit;
   logic autoWake;
   logic freezeLeft;
   logic enterSync;
   logic runDone;
   logic detectClear;
   logic freezeCycled;
   logic next_freezeCycled;
   logic next_busOff;
   logic busoffCounting;
   logic busoffReached;
   logic fifoFull;

   // ****************************************************************
   // APB decode
   // ****************************************************************

   // Address match and phase of the current transfer
   assign ctrlAddr = ADDR_WIDTH'(`CTRL_OFFSET);
   assign statusAddr = ADDR_WIDTH'(`STATUS_OFFSET);
   assign hitCtrl = (paddr == ctrlAddr);
   assign hitStatus = (paddr == statusAddr);
   assign mapped = hitCtrl || hitStatus;
   assign setupCycle = psel && !penable;
   assign accessCycle = psel && penable;
   assign wrCtrl = accessCycle && pwrite && hitCtrl;

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = accessCycle && !mapped;

   // Read data source, with reserved bits at zero
   always_comb
   begin
      readValue = `READ_ZERO;
      if (hitCtrl)
      begin
         readValue = ctrl;
         readValue[`PARTIAL_RESET_BIT] = partialPending;
      end
      else if (hitStatus)
      begin
         readValue[`FREEZE_ACK_BIT] = freezeAck;
         readValue[`SLEEP_ACK_BIT] = sleepAck;
      end
   end

   // ****************************************************************
   // Control register
   // ****************************************************************

   // Control fields seen by the rest of the block
   assign sleepReq = ctrl[`SLEEP_REQ_BIT];
   assign freezeReq = ctrl[`FREEZE_REQ_BIT];
   assign autoSleepExit = ctrl[`AUTO_SLEEP_BIT];
   assign autoBusoffExit = ctrl[`AUTO_BUSOFF_BIT];

   // Next register state: write, automatic wake, partial reset
   always_comb
   begin
      next_ctrl = ctrl;
      next_partialPending = 1'b0;
      next_prdata = prdata;
      if (autoWake)
         next_ctrl[`SLEEP_REQ_BIT] = 1'b0;
      if (wrCtrl)
      begin
         // Only defined fields are stored
         next_ctrl = pwdata & `CTRL_WMASK;
         // Writing one starts a partial reset, zero does nothing
         if (pwdata[`PARTIAL_RESET_BIT])
            next_partialPending = 1'b1;
      end
      // Pending partial reset loads the reset value, overriding a write
      if (partialPending)
         next_ctrl = `CTRL_RESET;
      // Read data is captured in the setup cycle
      if (setupCycle)
         next_prdata = readValue;
   end

   // Register file flip-flops
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl <= `CTRL_RESET;
         partialPending <= 1'b0;
         prdata <= `READ_ZERO;
      end
      else
      begin
         ctrl <= next_ctrl;
         partialPending <= next_partialPending;
         prdata <= next_prdata;
      end
   end

   // Receive FIFOs are cleared while the partial reset is pending
   assign rxFifoReset = partialPending;

   // ****************************************************************
   // Option outputs
   // ****************************************************************

   // Options passed to the protocol engine and mailboxes
   assign timeTriggeredMode = ctrl[`TIME_TRIG_BIT];
   assign retransmitProhibit = ctrl[`RETX_PROHIBIT_BIT];
   assign txPriorityRule = ctrl[`PRIO_RULE_BIT];

   // Transmit is held only while halted with both debug bits set
   assign txBlocked = ctrl[`DBG_TX_BLOCK_BIT] && debugCanPause
      && debugHalt;
   assign txAllowed = busOnline && !txBlocked;

   // Overflow rule, applied only when a full FIFO gets a new message
   assign fifoFull = (rxFifoMessageCount == `FIFO_FULL_COUNT);
   assign discardOldest = rxValidMessage && fifoFull
      && !ctrl[`DISCARD_SEL_BIT];
   assign dropIncoming = rxValidMessage && fifoFull
      && ctrl[`DISCARD_SEL_BIT];

   // ****************************************************************
   // Operating mode
   // ****************************************************************

   // Bus message seen while sleeping with automatic wake enabled
   assign autoWake = (mode == can_master_control_pkg::MODE_SLEEP)
      && autoSleepExit && sofDetected;

   // Mode transitions
   always_comb
   begin
      next_mode = mode;
      unique case (mode)
         can_master_control_pkg::MODE_SLEEP:
         begin
            // Leave on cleared request or on automatic wake
            if (!sleepReq || autoWake)
            begin
               if (freezeReq)
                  next_mode = can_master_control_pkg::MODE_FREEZE;
               else
                  next_mode = can_master_control_pkg::MODE_SYNC;
            end
         end
         can_master_control_pkg::MODE_FREEZE:
         begin
            if (!freezeReq)
               next_mode = can_master_control_pkg::MODE_SYNC;
         end
         can_master_control_pkg::MODE_SYNC:
         begin
            if (sleepReq)
               next_mode = can_master_control_pkg::MODE_SLEEP;
            else if (freezeReq)
               next_mode = can_master_control_pkg::MODE_FREEZE;
            else if (runDone)
               next_mode = can_master_control_pkg::MODE_ONLINE;
         end
         can_master_control_pkg::MODE_ONLINE:
         begin
            // Wait for the frame in progress to finish
            if (!busActive)
            begin
               if (freezeReq)
                  next_mode = can_master_control_pkg::MODE_FREEZE;
               else if (sleepReq)
                  next_mode = can_master_control_pkg::MODE_SLEEP;
            end
         end
      endcase
      if (partialPending)
         next_mode = can_master_control_pkg::MODE_SLEEP;
   end

   // Mode register, sleeping after reset
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         mode <= can_master_control_pkg::MODE_SLEEP;
      else
         mode <= next_mode;
   end

   // Acknowledges follow the mode actually reached
   assign sleepAck = (mode == can_master_control_pkg::MODE_SLEEP);
   assign freezeAck = (mode == can_master_control_pkg::MODE_FREEZE);
   assign busOnline = (mode == can_master_control_pkg::MODE_ONLINE)
      && !busOff;

   // Mode change markers
   assign freezeLeft = (mode == can_master_control_pkg::MODE_FREEZE)
      && (next_mode != can_master_control_pkg::MODE_FREEZE);
   assign enterSync = (mode != can_master_control_pkg::MODE_SYNC)
      && (next_mode == can_master_control_pkg::MODE_SYNC);

   // ****************************************************************
   // Recessive run detection
   // ****************************************************************

   // Runs restart on entry to sync and when nobody needs them
   assign detectClear = enterSync
      || !((mode == can_master_control_pkg::MODE_SYNC) || busoffCounting);

   // Eleven consecutive recessive samples
   recessive_run_detect
   #(
      .RUN_LEN(RUN_LEN)
   )
   runDetect
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(detectClear),
      .sampleTick(sampleTick),
      .rxLevel(rxLevel),
      .runDone(runDone)
   );

   // ****************************************************************
   // Bus-off recovery
   // ****************************************************************

   // Exit timing is counted with auto exit or after a freeze cycle
   assign busoffCounting = busOff
      && (autoBusoffExit || freezeCycled);

   // Occurrences of the recessive run while bus-off
   event_counter
   #(
      .COUNT(BUSOFF_RUNS)
   )
   busoffRuns
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(!busoffCounting),
      .eventIn(runDone),
      .reached(busoffReached)
   );

   // Bus-off state; entering wins over leaving in the same cycle
   always_comb
   begin
      next_busOff = busOff;
      next_freezeCycled = freezeCycled;
      if (busOff && freezeLeft)
         next_freezeCycled = 1'b1;
      if (busoffReached)
      begin
         next_busOff = 1'b0;
         next_freezeCycled = 1'b0;
      end
      if (busOffEnter)
      begin
         next_busOff = 1'b1;
         next_freezeCycled = 1'b0;
      end
   end

   // Bus-off flip-flops
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busOff <= 1'b0;
         freezeCycled <= 1'b0;
      end
      else
      begin
         busOff <= next_busOff;
         freezeCycled <= next_freezeCycled;
      end
   end

endmodule

//--- tb/can_master_control_properties.sv
// Concurrent checks on the ports of the master control block.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps

module can_master_control_properties
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Inputs watched
   input wire logic debugHalt,
   input wire logic debugCanPause,
   input wire logic rxValidMessage,
   input wire logic [1:0] rxFifoMessageCount,
   input wire logic busActive,
   input wire logic busOffEnter,
   input wire logic sampleTick,
   input wire logic rxLevel,
   // Outputs watched
   input wire logic rxFifoReset,
   input wire logic discardOldest,
   input wire logic dropIncoming,
   input wire logic txBlocked,
   input wire logic txAllowed,
   input wire logic busOnline,
   input wire logic busOff,
   input wire logic sleepAck,
   input wire logic freezeAck
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Transmit gating
   a_block_needs_both:
   assert property (!(debugHalt && debugCanPause) |-> !txBlocked)
      else $error("transmit blocked without halt and pause");
   a_tx_allowed_rule:
   assert property (txAllowed == (busOnline && !txBlocked))
      else $error("transmit permission wrong");
   // Overflow strobes
   a_overflow_handled:
   assert property (rxValidMessage && rxFifoMessageCount == 2'h3
      |-> discardOldest != dropIncoming)
      else $error("overflow not resolved by exactly one rule");
   a_overflow_only_full:
   assert property ((discardOldest || dropIncoming)
      |-> rxValidMessage && rxFifoMessageCount == 2'h3)
      else $error("overflow strobe without full fifo");
   // Partial reset and modes
   a_partial_to_sleep:
   assert property (rxFifoReset |=> sleepAck && !rxFifoReset)
      else $error("partial reset did not end in sleep");
   a_acks_exclusive:
   assert property (!(sleepAck && freezeAck))
      else $error("sleep and freeze acknowledged together");
   a_online_clean_mode:
   assert property (busOnline |-> !sleepAck && !freezeAck && !busOff)
      else $error("online while asleep, frozen or bus-off");
   a_freeze_waits_idle:
   assert property (busOnline && busActive && !rxFifoReset
      |=> !freezeAck && !sleepAck)
      else $error("mode left during bus activity");
   a_online_after_run:
   assert property ($rose(busOnline) && !$past(busOff)
      |-> $past(sampleTick, 2) && $past(rxLevel, 2))
      else $error("online without recessive sample");
   // Bus-off
   a_busoff_entry:
   assert property (busOffEnter |=> busOff)
      else $error("bus-off not entered");
   a_busoff_holds:
   assert property ($rose(busOff) |-> busOff[*8])
      else $error("bus-off left too early");
   a_busoff_exit_run:
   assert property ($fell(busOff) |-> $past(sampleTick, 3)
      && $past(rxLevel, 3))
      else $error("bus-off left without a recessive run");
endmodule

bind can_master_control can_master_control_properties chk
(
   .clk, .sys_rst, .debugHalt, .debugCanPause, .rxValidMessage,
   .rxFifoMessageCount, .busActive, .busOffEnter, .sampleTick, .rxLevel,
   .rxFifoReset, .discardOldest, .dropIncoming, .txBlocked, .txAllowed,
   .busOnline, .busOff, .sleepAck, .freezeAck
);

//--- tb/can_bus_node.sv
// Model of the other nodes on the shared CAN bus.
// Assumes a bit time of four clocks; an idle bus reads recessive.
`timescale 1ns/1ps

module can_bus_node
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Command from the bench
   input wire logic sendFrame,
   // Bus view towards the block
   output logic sampleTick,
   output logic rxLevel,
   output logic busActive,
   output logic sofDetected
);
   logic [1:0] phase;
   logic [4:0] bitsLeft;
   int seed = 78984;

   // Bit timer and frame of sixteen bits with random content
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         phase <= 2'h0;
         bitsLeft <= 5'h00;
         rxLevel <= 1'b1;
         sofDetected <= 1'b0;
      end
      else
      begin
         phase <= phase + 2'h1;
         sofDetected <= 1'b0;
         if (sendFrame && bitsLeft == 5'h00)
         begin
            bitsLeft <= 5'h10;
            rxLevel <= 1'b0; // Start of frame is dominant
            sofDetected <= 1'b1;
         end
         else if (phase == 2'h3 && bitsLeft != 5'h00)
         begin
            bitsLeft <= bitsLeft - 5'h01;
            rxLevel <= (bitsLeft == 5'h01) ? 1'b1 : 1'($random(seed));
         end
      end
   end

   // Sample point and activity decode
   assign sampleTick = (phase == 2'h3);
   assign busActive = (bitsLeft != 5'h00);
endmodule

//--- tb/can_master_control_bench.sv
// Self-checking bench of the CAN master control block.
// Assumes the bus node model and shortened run counts of 3 and 4.
`timescale 1ns/1ps
`include "can_master_control_cfg.svh"

module can_master_control_bench;
   logic clk, pready, pslverr, sampleTick, rxLevel;
   logic sys_rst = 1, psel = 0, penable = 0, pwrite = 0, sendFrame = 0;
   logic busOffEnter = 0, debugHalt = 0, debugCanPause = 0;
   logic rxValidMessage = 0, err;
   logic [1:0] rxFifoMessageCount = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, v;
   logic busActive, sofDetected, rxFifoReset, discardOldest, dropIncoming;
   logic timeTriggeredMode, retransmitProhibit, txPriorityRule, txBlocked;
   logic txAllowed, busOnline, busOff, sleepAck, freezeAck;
   int fails = 0, checks = 0, seed = 78984;

   // Block and far side
   can_master_control #(.RUN_LEN(3), .BUSOFF_RUNS(4)) DUT
   (
      .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sampleTick, .rxLevel, .busActive, .sofDetected,
      .busOffEnter, .debugHalt, .debugCanPause, .rxValidMessage,
      .rxFifoMessageCount, .rxFifoReset, .discardOldest, .dropIncoming,
      .timeTriggeredMode, .retransmitProhibit, .txPriorityRule, .txBlocked,
      .txAllowed, .busOnline, .busOff, .sleepAck, .freezeAck
   );
   can_bus_node partner
   (
      .clk, .sys_rst, .sendFrame, .sampleTick, .rxLevel, .busActive,
      .sofDetected
   );

   // Clock of 4 ns
   initial
   begin
      clk = 0;
      forever #2 clk = ~clk;
   end

   // Expected values
   function automatic logic [31:0] ctrl_exp(input logic [31:0] d);
      return d & `CTRL_WMASK;
   endfunction
   function automatic logic blk_exp(input logic b, p, h);
      return b & p & h;
   endfunction

   // Comparisons
   task automatic check32(input logic [31:0] got, exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic checkb(input logic got, exp);
      check32({31'h0, got}, {31'h0, exp});
   endtask

   // APB transfer, full words only; result in rd and err
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Bounded wait for one status output, then compare
   task automatic waitfor(input int s, input logic val, input int lim);
      logic got;
      got = ~val;
      for (int i = 0; i < lim && got !== val; i++)
      begin
         @(posedge clk);
         #1;
         got = s == 0 ? sleepAck : s == 1 ? freezeAck :
            s == 2 ? busOnline : busOff;
      end
      checkb(got, val);
   endtask

   // One-cycle pulses towards the block and the bus model
   task automatic pulse_busoff;
      @(posedge clk);
      busOffEnter <= 1'b1;
      @(posedge clk);
      busOffEnter <= 1'b0;
   endtask
   task automatic frame;
      @(posedge clk);
      sendFrame <= 1'b1;
      @(posedge clk);
      sendFrame <= 1'b0;
   endtask

   task automatic print_verdict;
      if (fails == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      print_verdict;
   end

   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      apb(0, `CTRL_OFFSET, 0);
      check32(rd, 32'h0001_0002);
      apb(1, `STATUS_OFFSET, 32'hFFFF_FFFF);
      apb(0, `STATUS_OFFSET, 0);
      check32(rd, 32'h0000_0002);
      apb(0, 12'h010, 0);
      checkb(err, 1'b1);
      check32(rd, 32'h0000_0000);
      for (int i = 0; i < 8; i++)
      begin
         v = ($random(seed) & 32'hFFFF_7FFC) | 32'h0000_0002;
         v = (i == 0) ? 32'hFFFF_7FFE : v;
         apb(1, `CTRL_OFFSET, v);
         apb(0, `CTRL_OFFSET, 0);
         check32(rd, ctrl_exp(v));
         checkb(timeTriggeredMode, v[7]);
         checkb(retransmitProhibit, v[4]);
         checkb(txPriorityRule, v[2]);
      end
      for (int k = 0; k < 8; k++)
      begin
         apb(1, `CTRL_OFFSET, {15'h0, k[2], 12'h0, k[2], 3'h2});
         debugCanPause <= k[1];
         debugHalt <= k[0];
         rxValidMessage <= 1'b1;
         rxFifoMessageCount <= k[1:0];
         @(posedge clk);
         #1;
         checkb(txBlocked, blk_exp(k[2], k[1], k[0]));
         checkb(discardOldest, k[1:0] == 2'h3 && !k[2]);
         checkb(dropIncoming, k[1:0] == 2'h3 && k[2]);
         @(posedge clk);
         rxValidMessage <= 1'b0;
      end
      debugHalt <= 1'b0;
      apb(1, `CTRL_OFFSET, 0);
      waitfor(0, 1'b0, 10);
      checkb(busOnline, 1'b0);
      waitfor(2, 1'b1, 200);
      checkb(txAllowed, 1'b1);
      apb(1, `CTRL_OFFSET, 32'h0001_0000);
      debugHalt <= 1'b1;
      @(posedge clk);
      #1;
      checkb(txAllowed, 1'b0);
      frame;
      apb(1, `CTRL_OFFSET, 32'h0000_0001);
      repeat (8) @(posedge clk);
      #1;
      checkb(freezeAck, 1'b0);
      waitfor(1, 1'b1, 200);
      apb(0, `STATUS_OFFSET, 0);
      check32(rd, 32'h0000_0001);
      apb(1, `CTRL_OFFSET, 0);
      waitfor(1, 1'b0, 10);
      checkb(busOnline, 1'b0);
      waitfor(2, 1'b1, 200);
      apb(1, `CTRL_OFFSET, 32'h0000_0040);
      pulse_busoff;
      waitfor(3, 1'b1, 4);
      waitfor(3, 1'b0, 400);
      apb(1, `CTRL_OFFSET, 0);
      pulse_busoff;
      waitfor(3, 1'b1, 4);
      repeat (200) @(posedge clk);
      #1;
      checkb(busOff, 1'b1);
      apb(1, `CTRL_OFFSET, 32'h0000_0001);
      waitfor(1, 1'b1, 50);
      apb(1, `CTRL_OFFSET, 0);
      waitfor(3, 1'b0, 400);
      apb(1, `CTRL_OFFSET, 32'h0000_0022);
      waitfor(0, 1'b1, 50);
      frame;
      waitfor(0, 1'b0, 20);
      apb(0, `CTRL_OFFSET, 0);
      check32(rd, 32'h0000_0020);
      apb(1, `CTRL_OFFSET, 32'h0000_8080);
      #1;
      checkb(rxFifoReset, 1'b1);
      apb(0, `CTRL_OFFSET, 0);
      check32(rd, 32'h0001_0002);
      checkb(sleepAck, 1'b1);
      apb(1, `CTRL_OFFSET, 32'h0000_0080);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      apb(0, `CTRL_OFFSET, 0);
      check32(rd, 32'h0001_0002);
      print_verdict;
   end
endmodule
